// ---- mqf_defs.svh ----
// Constants for the multi-queue dual-clock FIFO block
//
// Operation
// [RULE1] Words leave the read port in the same order they entered the write port.
// [RULE2] With writing and input enabled, each write-clock rising edge stores the write bus.
// [RULE3] With reading and output enabled, each read-clock rising edge presents the next word.
// [RULE4] The outside system keeps the read over write clock ratio between one half and two.
// [RULE5] Empty shows when no unread word remains and full when no word can be stored.
// [RULE6] Storage splits into a configured number of independent queues, eight at most.
// [RULE7] A retransmit moves the read pointer back to the marked position.
// [RULE8] A mailbox register carries a word from input to output outside queue order.
// [RULE9] Port widths 9 to 36 bits behave alike except for the count of valid data bits.
// [RULE10] The input gate masks a write and the output gate gives a read skip.
// [RULE11] Master reset empties the whole buffer and every queue.
// [RULE12] Configuration loads over a parallel path or a serial path with its own clock.
// [RULE13] An enabled write advances the write pointer even when the input gate is off.
// [RULE14] Load select low targets configuration on bits 7 to 0, high targets the buffer.
// [RULE15] Empty is active low on the read clock and full is active low on the write clock.
// [RULE16] Master reset zeroes pointers and output, restores configuration and flags.
// [RULE17] Writes to a full queue are ignored and reads of an empty queue do not advance.
`ifndef MQF_DEFS_SVH
`define MQF_DEFS_SVH

// ========================================
// Register map
`define MQF_ADDR_CONFIG   12'h000
`define MQF_ADDR_FLAGS    12'h004
`define MQF_ADDR_IRQ_STAT 12'h008
`define MQF_ADDR_IRQ_MASK 12'h00C

// ========================================
// Reset values and fields
`define MQF_CFG_RESET     8'h00
`define MQF_QCNT_MSB      2
`define MQF_IRQ_OVF       0
`define MQF_IRQ_UNF       1
`define MQF_IRQ_MBX       2
`define MQF_IRQ_W         3

// ========================================
// Port width masks
`define MQF_MASK_X9       36'h0000001FF
`define MQF_MASK_X12      36'h000000FFF
`define MQF_MASK_X16      36'h00000FFFF
`define MQF_MASK_X18      36'h00003FFFF
`define MQF_MASK_X20      36'h0000FFFFF
`define MQF_MASK_X24      36'h000FFFFFF
`define MQF_MASK_X32      36'h0FFFFFFFF
`define MQF_MASK_X36      36'hFFFFFFFFF

`endif

// ---- mqf_pkg.sv ----
// Types shared by the multi-queue FIFO block
package mqf_pkg;

  // Pins from outside the pclk domain, synchronised as one bundle
  typedef struct packed {
    logic        wr_clk;
    logic        write_enable;
    logic        input_gate_n;
    logic [35:0] wr_data;
    logic [2:0]  write_queue_select;
    logic        mailbox_select;
    logic        config_load_select;
    logic        rd_clk;
    logic        read_enable;
    logic        output_gate_n;
    logic        retransmit_request;
    logic        mark_request;
    logic [2:0]  read_queue_select;
    logic [2:0]  port_width_select;
    logic        master_reset_in;
    logic        serial_clk;
    logic        serial_config_enable;
    logic        serial_data_in;
  } mqf_pins_s;

endpackage

// ---- mqf_sync.sv ----
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/100ps
module mqf_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ---- mqf_top.sv ----
// Multi-queue FIFO with pin-side ports sampled by pclk and APB registers
`timescale 1ns/100ps
`include "mqf_defs.svh"
module mqf_top #(
  parameter int QAW = 3
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Write port
  input  wire logic        wr_clk,
  input  wire logic        write_enable,
  input  wire logic        input_gate_n,
  input  wire logic [35:0] wr_data,
  input  wire logic [2:0]  write_queue_select,
  input  wire logic        mailbox_select,
  input  wire logic        config_load_select,
  // Read port
  input  wire logic        rd_clk,
  input  wire logic        read_enable,
  input  wire logic        output_gate_n,
  input  wire logic        retransmit_request,
  input  wire logic        mark_request,
  input  wire logic [2:0]  read_queue_select,
  output logic      [35:0] rd_data,
  output logic             rd_data_oe,
  output logic             output_word_valid,
  output logic      [2:0]  output_queue_tag,
  // Flags
  output logic             empty_flag_n,
  output logic             full_flag_n,
  output logic             irq,
  // Configuration and reset
  input  wire logic [2:0]  port_width_select,
  input  wire logic        master_reset_in,
  input  wire logic        serial_clk,
  input  wire logic        serial_config_enable,
  input  wire logic        serial_data_in
);

  localparam int QN = 8;
  localparam int AW = QAW + 3;
  localparam logic [QAW:0] QDEPTH = (QAW+1)'(1 << QAW);

  // ========================================
  // Pin synchronisers and edge finders
  mqf_pkg::mqf_pins_s pins_raw;
  mqf_pkg::mqf_pins_s pins;

  // Same order as the struct
  assign pins_raw = {wr_clk, write_enable, input_gate_n, wr_data, write_queue_select,
                     mailbox_select, config_load_select, rd_clk, read_enable,
                     output_gate_n, retransmit_request, mark_request, read_queue_select,
                     port_width_select, master_reset_in, serial_clk,
                     serial_config_enable, serial_data_in};

  mqf_sync #(.W($bits(mqf_pkg::mqf_pins_s))) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins_raw),
    .q     (pins)
  );

  logic wclk_d;
  logic rclk_d;
  logic sclk_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      wclk_d <= pins.wr_clk;
      rclk_d <= pins.rd_clk;
      sclk_d <= pins.serial_clk;
    end
  end

  logic wr_tick;
  logic rd_tick;
  logic s_tick;
  logic mreset;
  assign wr_tick = pins.wr_clk & ~wclk_d;
  assign rd_tick = pins.rd_clk & ~rclk_d;
  assign s_tick  = pins.serial_clk & ~sclk_d;
  assign mreset  = pins.master_reset_in;

  // ========================================
  // Configuration and width
  logic [7:0]  cfg_reg;
  logic [2:0]  wq;
  logic [2:0]  rq;
  logic        wq_ok;
  logic        rq_ok;
  logic [35:0] wmask;

  assign wq    = pins.write_queue_select;
  assign rq    = pins.read_queue_select;
  assign wq_ok = wq <= cfg_reg[`MQF_QCNT_MSB:0]; // [RULE6]
  assign rq_ok = rq <= cfg_reg[`MQF_QCNT_MSB:0]; // [RULE6]

  // Width only trims bus bits; queue behaviour is the same for all widths
  always_comb begin
    case (pins.port_width_select) // [RULE9]
      3'h0:    wmask = `MQF_MASK_X9;
      3'h1:    wmask = `MQF_MASK_X12;
      3'h2:    wmask = `MQF_MASK_X16;
      3'h3:    wmask = `MQF_MASK_X18;
      3'h4:    wmask = `MQF_MASK_X20;
      3'h5:    wmask = `MQF_MASK_X24;
      3'h6:    wmask = `MQF_MASK_X32;
      default: wmask = `MQF_MASK_X36;
    endcase
  end

  // ========================================
  // Queue pointers
  logic [QAW:0] wptr [QN];
  logic [QAW:0] rptr [QN];
  logic [QAW:0] mark [QN];
  logic [QN-1:0] q_empty;
  logic [QN-1:0] q_full;

  always_comb begin
    for (int i = 0; i < QN; i++) begin
      q_empty[i] = (wptr[i] == rptr[i]); // [RULE5]
      q_full[i]  = ((wptr[i] - rptr[i]) == QDEPTH); // [RULE5]
    end
  end

  logic wr_go;
  logic rd_go;
  logic wr_fifo;
  logic wr_ovf;
  logic wr_cfg;
  logic wr_mbx;
  logic rd_fifo;
  logic rd_unf;
  logic rd_cfg;
  logic rd_mbx;
  logic rtx_go;
  logic mark_go;

  assign wr_go   = wr_tick & pins.write_enable & ~mreset;
  assign rd_go   = rd_tick & pins.read_enable & ~mreset;
  assign wr_cfg  = wr_go & ~pins.config_load_select; // [RULE14]
  assign wr_mbx  = wr_go & pins.config_load_select & pins.mailbox_select;
  assign wr_fifo = wr_go & pins.config_load_select & ~pins.mailbox_select & wq_ok
                   & ~q_full[wq]; // [RULE17]
  assign wr_ovf  = wr_go & pins.config_load_select & ~pins.mailbox_select & ~wr_fifo;
  assign rd_cfg  = rd_go & ~pins.config_load_select; // [RULE14]
  assign rd_mbx  = rd_go & pins.config_load_select & pins.mailbox_select;
  assign rd_fifo = rd_go & pins.config_load_select & ~pins.mailbox_select & rq_ok
                   & ~q_empty[rq]; // [RULE17]
  assign rd_unf  = rd_go & pins.config_load_select & ~pins.mailbox_select & ~rd_fifo;
  assign rtx_go  = rd_tick & pins.retransmit_request & rq_ok & ~mreset;
  assign mark_go = rd_tick & pins.mark_request & rq_ok & ~mreset;

  // Write pointer moves even on a gated write; that slot keeps old data
  for (genvar g = 0; g < QN; g++) begin : g_q
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wptr[g] <= '0;
        rptr[g] <= '0;
        mark[g] <= '0;
      end else if (mreset) begin // [RULE11] [RULE16]
        wptr[g] <= '0;
        rptr[g] <= '0;
        mark[g] <= '0;
      end else begin
        if (wr_fifo && wq == 3'(g)) begin
          wptr[g] <= wptr[g] + 1'b1; // [RULE13]
        end
        if (rtx_go && rq == 3'(g)) begin
          rptr[g] <= mark[g]; // [RULE7]
        end else if (rd_fifo && rq == 3'(g)) begin
          rptr[g] <= rptr[g] + 1'b1; // [RULE1]
        end
        if (mark_go && rq == 3'(g)) begin
          mark[g] <= rptr[g];
        end
      end
    end
  end

  // ========================================
  // Storage and mailbox
  logic [35:0] mem [QN << QAW];
  logic [35:0] mbx_reg;
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [35:0] wr_word;
  logic [35:0] rd_word;

  assign wr_idx  = {wq, wptr[wq][QAW-1:0]};
  assign rd_idx  = {rq, rptr[rq][QAW-1:0]};
  assign wr_word = pins.wr_data & wmask;
  assign rd_word = mem[rd_idx];

  // Data only, so no reset; pointers define what is valid
  always_ff @(posedge pclk) begin
    if (wr_fifo && !pins.input_gate_n) begin
      mem[wr_idx] <= wr_word; // [RULE2] [RULE10]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbx_reg <= '0;
    end else if (mreset) begin
      mbx_reg <= '0;
    end else if (wr_mbx) begin
      mbx_reg <= wr_word; // [RULE8]
    end
  end

  // ========================================
  // Read port outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data           <= '0;
      output_word_valid <= 1'b0;
      output_queue_tag  <= '0;
    end else if (mreset) begin
      rd_data           <= '0; // [RULE16]
      output_word_valid <= 1'b0;
      output_queue_tag  <= '0;
    end else begin
      output_word_valid <= 1'b0;
      if (rd_fifo && !pins.output_gate_n) begin
        rd_data           <= rd_word; // [RULE3]
        output_word_valid <= 1'b1;
        output_queue_tag  <= rq;
      end else if (rd_mbx) begin
        rd_data           <= mbx_reg; // [RULE8]
        output_word_valid <= 1'b1;
      end else if (rd_cfg) begin
        rd_data <= {28'h0000000, cfg_reg}; // [RULE14]
      end
    end
  end

  // Gated read still advances: that is the read skip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_oe <= 1'b0;
    end else begin
      rd_data_oe <= ~pins.output_gate_n; // [RULE10]
    end
  end

  // Flags follow the selected queues; an unused queue reads as empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      empty_flag_n <= 1'b0;
      full_flag_n  <= 1'b1;
    end else if (mreset) begin
      empty_flag_n <= 1'b0; // [RULE16]
      full_flag_n  <= 1'b1;
    end else begin
      empty_flag_n <= rq_ok & ~q_empty[rq]; // [RULE15]
      full_flag_n  <= ~(wq_ok & q_full[wq]); // [RULE15]
    end
  end

  // ========================================
  // APB slave, one wait state per access
  logic acc;
  logic take;
  logic apb_cfg_wr;
  logic ser_go;
  logic [31:0] rd_mux;
  logic        rd_err;
  logic [`MQF_IRQ_W-1:0] irq_stat_reg;
  logic [`MQF_IRQ_W-1:0] irq_mask_reg;
  logic [`MQF_IRQ_W-1:0] irq_ev;

  assign acc        = psel & penable;
  assign take       = acc & pready & pwrite;
  assign apb_cfg_wr = take & (paddr == `MQF_ADDR_CONFIG);
  assign ser_go     = s_tick & pins.serial_config_enable;

  always_comb begin
    rd_err = 1'b0;
    case (paddr)
      `MQF_ADDR_CONFIG:   rd_mux = {24'h000000, cfg_reg};
      `MQF_ADDR_FLAGS:    rd_mux = {16'h0000, q_full, q_empty};
      `MQF_ADDR_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_reg};
      `MQF_ADDR_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_reg};
      default: begin
        rd_mux = 32'h00000000;
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & rd_err;
      if (acc && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // Priority: master reset, APB, parallel load, serial shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `MQF_CFG_RESET;
    end else if (mreset) begin
      cfg_reg <= `MQF_CFG_RESET; // [RULE16]
    end else if (apb_cfg_wr) begin
      cfg_reg <= pwdata[7:0];
    end else if (wr_cfg) begin
      cfg_reg <= pins.wr_data[7:0]; // [RULE12] [RULE14]
    end else if (ser_go) begin
      cfg_reg <= {cfg_reg[6:0], pins.serial_data_in}; // [RULE12]
    end
  end

  // ========================================
  // Interrupts: sticky, write one to clear, set wins
  always_comb begin
    irq_ev                = '0;
    irq_ev[`MQF_IRQ_OVF] = wr_ovf;
    irq_ev[`MQF_IRQ_UNF] = rd_unf;
    irq_ev[`MQF_IRQ_MBX] = wr_mbx;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq          <= 1'b0;
    end else begin
      if (take && paddr == `MQF_ADDR_IRQ_MASK) begin
        irq_mask_reg <= pwdata[`MQF_IRQ_W-1:0];
      end
      if (take && paddr == `MQF_ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata[`MQF_IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_ev;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ========================================
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [QAW:0] wptr_sel;
  logic [QAW:0] rptr_sel;
  logic [QAW:0] mark_sel;
  assign wptr_sel = wptr[wq];
  assign rptr_sel = rptr[rq];
  assign mark_sel = mark[rq];

  sequence s_rtx;
    rtx_go ##1 (rq == $past(rq));
  endsequence

  sequence s_ovf;
    wr_ovf && wq_ok ##1 (wq == $past(wq));
  endsequence

  a_read_order: assert property ( // [RULE1]
    rd_fifo && !pins.output_gate_n |=> rd_data == $past(rd_word))
    else $error("read word not the stored one");
  a_write_store: assert property ( // [RULE2]
    wr_fifo && !pins.input_gate_n |=> mem[$past(wr_idx)] == $past(wr_word))
    else $error("write word not stored");
  a_read_valid: assert property ( // [RULE3]
    rd_fifo && !pins.output_gate_n |=> output_word_valid && output_queue_tag == $past(rq))
    else $error("read valid or tag wrong");
  a_empty_show: assert property ( // [RULE15]
    !mreset && rq_ok && q_empty[rq] |=> !empty_flag_n)
    else $error("empty flag missing");
  a_retransmit_ptr: assert property ( // [RULE7]
    s_rtx |-> rptr_sel == $past(mark_sel))
    else $error("retransmit pointer wrong");
  a_mailbox_out: assert property ( // [RULE8]
    rd_mbx |=> rd_data == $past(mbx_reg) && output_word_valid)
    else $error("mailbox word not output");
  a_width_trim: assert property ( // [RULE9]
    wr_mbx |=> (mbx_reg & ~$past(wmask)) == 36'h000000000)
    else $error("bits beyond width kept");
  a_gated_write: assert property ( // [RULE10]
    wr_fifo && pins.input_gate_n |=> mem[$past(wr_idx)] == $past(mem[wr_idx]))
    else $error("gated write changed storage");
  a_reset_clear: assert property ( // [RULE11]
    mreset |=> q_empty == 8'hFF && rd_data == 36'h000000000
               && cfg_reg == `MQF_CFG_RESET && !empty_flag_n)
    else $error("master reset incomplete");
  a_full_ignore: assert property ( // [RULE17]
    s_ovf |-> wptr_sel == $past(wptr_sel))
    else $error("write to full queue moved pointer");
  a_serial_shift: assert property ( // [RULE12]
    ser_go && !mreset && !apb_cfg_wr && !wr_cfg
    |=> cfg_reg == {$past(cfg_reg[6:0]), $past(pins.serial_data_in)})
    else $error("serial shift wrong");

endmodule

// ---- mqf_link_model.sv ----
// Far-side model: producer and consumer link clocks
`timescale 1ns/100ps
module mqf_link_model (
  // Link clocks
  output logic wr_clk,
  output logic rd_clk
);
  // ========================================
  // Equal rates, offset phase; ratio of one sits inside the allowed band
  initial begin
    wr_clk = 1'b0;
    forever #400 wr_clk = ~wr_clk;
  end
  initial begin
    rd_clk = 1'b0;
    #130;
    forever #400 rd_clk = ~rd_clk;
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the multi-queue FIFO block
`timescale 1ns/100ps
`include "mqf_defs.svh"
module testbench;
  typedef struct packed {logic [2:0] ws; logic [2:0] q; logic [35:0] d; logic [35:0] e;} mqf_row_s;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, rs;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rv;
  mqf_pkg::mqf_pins_s p;
  logic              wr_clk, rd_clk, oe, vld, efn, ffn, irq;
  logic [35:0]       rdd;
  logic [2:0]        tag;
  int                errors, n_tests, n_vld;
  mqf_row_s          rows [8] = '{
    '{3'h0, 3'h0, 36'hFFFFFFFFF, 36'h0000001FF}, '{3'h1, 3'h1, 36'hABCDE1234, 36'h000000234},
    '{3'h2, 3'h0, 36'hFFFFFFFFF, 36'h00000FFFF}, '{3'h3, 3'h1, 36'hABCDE1234, 36'h000021234},
    '{3'h4, 3'h0, 36'hFFFFFFFFF, 36'h0000FFFFF}, '{3'h5, 3'h1, 36'hABCDE1234, 36'h000DE1234},
    '{3'h6, 3'h0, 36'hFFFFFFFFF, 36'h0FFFFFFFF}, '{3'h7, 3'h1, 36'hABCDE1234, 36'hABCDE1234}};

  mqf_link_model u_link (.wr_clk(wr_clk), .rd_clk(rd_clk));
  mqf_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_clk(wr_clk), .write_enable(p.write_enable),
    .input_gate_n(p.input_gate_n), .wr_data(p.wr_data), .write_queue_select(p.write_queue_select),
    .mailbox_select(p.mailbox_select), .config_load_select(p.config_load_select),
    .rd_clk(rd_clk), .read_enable(p.read_enable), .output_gate_n(p.output_gate_n),
    .retransmit_request(p.retransmit_request), .mark_request(p.mark_request),
    .read_queue_select(p.read_queue_select), .rd_data(rdd), .rd_data_oe(oe),
    .output_word_valid(vld), .output_queue_tag(tag), .empty_flag_n(efn), .full_flag_n(ffn),
    .irq(irq), .port_width_select(p.port_width_select), .master_reset_in(p.master_reset_in),
    .serial_clk(p.serial_clk), .serial_config_enable(p.serial_config_enable),
    .serial_data_in(p.serial_data_in));

  // ========================================
  // Clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #3000000;
    errors++;
    final_report();
  end
  // Valid stands one cycle, so it is counted at every edge
  always @(posedge pclk) begin
    if (vld === 1'b1) n_vld++;
  end

  // ========================================
  // Shared tasks
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Held from setup until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    rs = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Pins change in the low phase so they are steady around the rise
  task automatic wr(input logic [2:0] q, input logic [35:0] d, input logic g, mb, ld);
    @(negedge wr_clk);
    @(posedge pclk);
    p.write_enable <= 1'b1; p.wr_data <= d; p.write_queue_select <= q;
    p.input_gate_n <= g; p.mailbox_select <= mb; p.config_load_select <= ld;
    @(posedge wr_clk);
    @(negedge wr_clk);
    @(posedge pclk);
    p.write_enable <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic rd(input logic en, g, mk, rt, mb, ld);
    @(negedge rd_clk);
    @(posedge pclk);
    p.read_enable <= en; p.output_gate_n <= g; p.mark_request <= mk;
    p.retransmit_request <= rt; p.mailbox_select <= mb; p.config_load_select <= ld;
    @(posedge rd_clk);
    repeat (7) @(posedge pclk);
    p.read_enable <= 1'b0; p.mark_request <= 1'b0; p.retransmit_request <= 1'b0;
  endtask
  task automatic final_report();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ========================================
  // Main sequence
  initial begin
    errors = 0; n_tests = 0; presetn = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    p = '0;
    p.config_load_select = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(efn, 1'b0);
    chk(ffn, 1'b1);
    chk(rdd, 36'h0);
    apb(1'b0, `MQF_ADDR_CONFIG, 32'h0);
    chk(rv, 32'h0);
    apb(1'b1, `MQF_ADDR_CONFIG, 32'h1);
    // Rows: widths and two queues
    foreach (rows[i]) begin
      p.port_width_select <= rows[i].ws;
      p.read_queue_select <= rows[i].q;
      wr(rows[i].q, rows[i].d, 1'b0, 1'b0, 1'b1);
      rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      chk(rdd, rows[i].e);
      chk(tag, rows[i].q);
      chk(n_vld, i + 1);
      chk(efn, 1'b0);
    end
    p.read_queue_select <= 3'h0;
    // Fill until full, overflow, drain in order, underflow
    for (int i = 0; i < 8; i++) wr(3'h0, 36'h100 + i, 1'b0, 1'b0, 1'b1);
    chk(ffn, 1'b0);
    wr(3'h0, 36'h999, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      chk(rdd, 36'h100 + (i < 8 ? i : 7));
    end
    chk(n_vld, 16);
    chk(efn, 1'b0);
    apb(1'b1, `MQF_ADDR_IRQ_MASK, 32'h1);
    apb(1'b0, `MQF_ADDR_IRQ_STAT, 32'h0);
    chk(rv, 32'h3);
    chk(irq, 1'b1);
    apb(1'b1, `MQF_ADDR_IRQ_STAT, 32'h3);
    // Interrupt output trails the status by one cycle
    @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rs, 1'b1);
    // Masked write leaves a hole; read skip holds the output
    for (int i = 0; i < 5; i++) wr(3'h0, 36'hA0 + i, i == 1, 1'b0, 1'b1);
    rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(rdd, 36'hA0);
    chk(oe, 1'b1);
    repeat (2) rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(rdd, 36'hA2);
    rd(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(rdd, 36'hA2);
    chk(oe, 1'b0);
    chk(n_vld, 19);
    rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(rdd, 36'hA4);
    // Mark, read two, retransmit, read again
    wr(3'h0, 36'hF1, 1'b0, 1'b0, 1'b1);
    wr(3'h0, 36'hF2, 1'b0, 1'b0, 1'b1);
    rd(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    repeat (2) rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(rdd, 36'hF2);
    rd(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    chk(rdd, 36'hF1);
    rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    // Mailbox bypasses the queue
    wr(3'h0, 36'h5A5A5, 1'b0, 1'b1, 1'b1);
    chk(efn, 1'b0);
    rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    chk(rdd, 36'h5A5A5);
    apb(1'b0, `MQF_ADDR_IRQ_STAT, 32'h0);
    chk(rv, 32'h4);
    // A queue beyond the configured count refuses the write
    wr(3'h5, 36'h1, 1'b0, 1'b0, 1'b1);
    apb(1'b0, `MQF_ADDR_IRQ_STAT, 32'h0);
    chk(rv, 32'h5);
    // Parallel and serial configuration
    wr(3'h0, 36'h2, 1'b0, 1'b0, 1'b0);
    apb(1'b0, `MQF_ADDR_CONFIG, 32'h0);
    chk(rv, 32'h2);
    rd(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(rdd[7:0], 8'h02);
    p.serial_config_enable <= 1'b1;
    for (int b = 7; b >= 0; b--) begin
      p.serial_data_in <= b[0];
      repeat (4) @(posedge pclk);
      p.serial_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      p.serial_clk <= 1'b0;
    end
    p.serial_config_enable <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, `MQF_ADDR_CONFIG, 32'h0);
    // First bit shifted lands in the top bit
    chk(rv, 32'hAA);
    // Master reset mid-run
    wr(3'h0, 36'h77, 1'b0, 1'b0, 1'b1);
    p.master_reset_in <= 1'b1;
    repeat (10) @(posedge pclk);
    p.master_reset_in <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(efn, 1'b0);
    chk(rdd, 36'h0);
    apb(1'b0, `MQF_ADDR_CONFIG, 32'h0);
    chk(rv, 32'h0);
    final_report();
  end
endmodule
